// ===== design/ivpm_pkg.sv
// Constants and carriers of the interrupt vector and priority map.
`default_nettype none
package ivpm_pkg;

    // --------------------------------------------------------------
    // Widths and vector layout
    // --------------------------------------------------------------
    localparam int unsigned NUM_LEVELS = 25;
    localparam int unsigned LVL_W = 5;
    localparam int unsigned VEC_W = 24;
    localparam logic [VEC_W-1:0] VEC_RESET = 24'h008000;
    localparam logic [VEC_W-1:0] VEC_TRAP = 24'h008004;
    localparam logic [VEC_W-1:0] VEC_LEVEL0 = 24'h008008;
    localparam int unsigned VEC_STRIDE_SHIFT = 2;

    // --------------------------------------------------------------
    // Wake capability per level and connected sources
    // --------------------------------------------------------------
    // Levels 1, 3-7, 10 and 19 may wake from Halt.
    localparam logic [NUM_LEVELS-1:0] WAKE_MASK = 25'h00804fa;
    // Levels 8, 9, 17 and 18 have no source.
    localparam logic [NUM_LEVELS-1:0] USED_MASK = 25'h1f9fcff;

    // --------------------------------------------------------------
    // Carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic numbered;
        logic [LVL_W-1:0] level;
        logic [VEC_W-1:0] vector;
    } ivpm_grant_s;

endpackage : ivpm_pkg
`default_nettype wire

// ===== design/ivpm_pick.sv
// Lowest-number priority pick over the pending request levels.
`timescale 1ns/1ps
`default_nettype none
module ivpm_pick (
    // Pending requests, already masked to connected levels
    input wire logic [ivpm_pkg::NUM_LEVELS-1:0] i_req,
    // Winner
    output logic o_any,
    output logic [ivpm_pkg::LVL_W-1:0] o_level
);
    always_comb begin
        o_any = 1'b0;
        o_level = '0;
        for (int i = ivpm_pkg::NUM_LEVELS - 1; i >= 0; i--) begin
            if (i_req[i]) begin
                o_any = 1'b1;
                o_level = ivpm_pkg::LVL_W'(i);
            end
        end
    end
endmodule : ivpm_pick
`default_nettype wire

// ===== design/ivpm_top.sv
// Interrupt vector and priority map: picks a request and presents its vector.
`timescale 1ns/1ps
`default_nettype none
module ivpm_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Request sources, bit n is numbered level n
    input wire logic [ivpm_pkg::NUM_LEVELS-1:0] i_irq,
    input wire logic i_trap,
    // Core state
    input wire logic i_halted,
    // Grant to the core
    output logic o_valid,
    output logic o_numbered,
    output logic [ivpm_pkg::LVL_W-1:0] o_level,
    output logic [ivpm_pkg::VEC_W-1:0] o_vector,
    output logic o_wake
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ivpm_pkg::ivpm_grant_s grant;
        logic wake;
        logic in_reset;
    } ivpm_state_s;

    ivpm_state_s state_q;
    ivpm_state_s state_d;
    logic pick_any;
    logic [ivpm_pkg::LVL_W-1:0] pick_level;
    logic [ivpm_pkg::NUM_LEVELS-1:0] live_req;

    function automatic logic [ivpm_pkg::VEC_W-1:0] level_vector(input logic [ivpm_pkg::LVL_W-1:0] lvl);
        level_vector = ivpm_pkg::VEC_LEVEL0 + (ivpm_pkg::VEC_W'(lvl) << ivpm_pkg::VEC_STRIDE_SHIFT);
    endfunction : level_vector

    // Reserved levels are cut off so a stray line can never raise a grant.
    assign live_req = i_irq & ivpm_pkg::USED_MASK;

    ivpm_pick u_pick (
        .i_req(live_req),
        .o_any(pick_any),
        .o_level(pick_level)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.in_reset = 1'b0;
        state_d.wake = 1'b0;
        state_d.grant = '0;
        if (i_trap) begin
            state_d.grant.valid = 1'b1;
            state_d.grant.vector = ivpm_pkg::VEC_TRAP;
        end else if (pick_any) begin
            // Fixed map: levels 0..24 land on slots 0x008008..0x008068.
            state_d.grant.valid = 1'b1;
            state_d.grant.numbered = 1'b1;
            state_d.grant.level = pick_level;
            state_d.grant.vector = level_vector(pick_level);
        end
        // Wake uses any capable line, not only the winner.
        if (i_halted && |(live_req & ivpm_pkg::WAKE_MASK)) begin
            state_d.wake = 1'b1;
        end
        if (i_srst) begin
            state_d = '0;
            state_d.in_reset = 1'b1;
            state_d.wake = 1'b1;
            state_d.grant.valid = 1'b1;
            state_d.grant.vector = ivpm_pkg::VEC_RESET;
        end
    end

    always_ff @(posedge i_clk) begin
        state_q <= state_d;
    end

    assign o_valid = state_q.grant.valid;
    assign o_numbered = state_q.grant.numbered;
    assign o_level = state_q.grant.level;
    assign o_vector = state_q.grant.vector;
    assign o_wake = state_q.wake;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    reset_vector_a: assert property (@(posedge i_clk) i_srst |=> o_vector == 24'h008000 && o_wake)
        else $error("reset vector wrong");
    trap_vector_a: assert property (@(posedge i_clk) disable iff (i_srst) i_trap |=> o_vector == 24'h008004 && !o_numbered)
        else $error("trap vector wrong");
    level_slot_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_numbered |-> o_vector == 24'h008008 + {17'h0, o_level, 2'h0})
        else $error("vector slot mismatch");
    lowest_wins_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[0] |=> o_numbered && o_level == 5'h00)
        else $error("level 0 not served");
    reserved_idle_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_numbered |-> !(o_level inside {5'd8, 5'd9, 5'd17, 5'd18}))
        else $error("reserved level granted");
    no_wake_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_irq & 25'h00804fa) == '0 |=> !o_wake)
        else $error("wake from incapable source");
    port_wake_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_halted && i_irq[3] |=> o_wake)
        else $error("port line did not wake");
    i2c_wake_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_halted && i_irq[19] |=> o_wake)
        else $error("i2c did not wake");

    // ----------------------------------------------------------------
    // Per-source slots
    // ----------------------------------------------------------------
    // Each check fires when its source is the lowest pending request, higher ones allowed, and pins that source to its level and slot.
    top_slot_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[0]
        |=> o_level == 5'd0 && o_vector == 24'h008008)
        else $error("top level slot wrong");
    wakeup_slot_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[1] && !i_irq[0]
        |=> o_level == 5'd1 && o_vector == 24'h00800c)
        else $error("auto wakeup slot wrong");
    clock_slot_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[2] && i_irq[1:0] == '0
        |=> o_level == 5'd2 && o_vector == 24'h008010)
        else $error("clock controller slot wrong");
    port_a_slot_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[3] && i_irq[2:0] == '0
        |=> o_level == 5'd3 && o_vector == 24'h008014)
        else $error("port a slot wrong");
    port_e_slot_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[7] && i_irq[6:0] == '0
        |=> o_level == 5'd7 && o_vector == 24'h008024)
        else $error("port e slot wrong");
    spi_slot_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[10] && i_irq[9:0] == '0
        |=> o_level == 5'd10 && o_vector == 24'h008030)
        else $error("spi slot wrong");
    update_slot_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[11] && i_irq[10:0] == '0
        |=> o_level == 5'd11 && o_vector == 24'h008034)
        else $error("first timer update slot wrong");
    capture_slot_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[12] && i_irq[11:0] == '0
        |=> o_level == 5'd12 && o_vector == 24'h008038)
        else $error("first timer capture slot wrong");
    second_update_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[13] && i_irq[12:0] == '0
        |=> o_level == 5'd13 && o_vector == 24'h00803c && !o_wake)
        else $error("second timer update slot wrong");
    second_capture_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[14] && i_irq[13:0] == '0
        |=> o_level == 5'd14 && o_vector == 24'h008040)
        else $error("second timer capture slot wrong");
    third_update_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[15] && i_irq[14:0] == '0
        |=> o_level == 5'd15 && o_vector == 24'h008044)
        else $error("third timer update slot wrong");
    third_capture_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[16] && i_irq[15:0] == '0
        |=> o_level == 5'd16 && o_vector == 24'h008048)
        else $error("third timer capture slot wrong");
    i2c_slot_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[19] && i_irq[18:0] == '0
        |=> o_level == 5'd19 && o_vector == 24'h008054)
        else $error("i2c slot wrong");
    serial_tx_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[20] && i_irq[19:0] == '0
        |=> o_level == 5'd20 && o_vector == 24'h008058)
        else $error("serial transmit slot wrong");
    serial_rx_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[21] && i_irq[20:0] == '0
        |=> o_level == 5'd21 && o_vector == 24'h00805c)
        else $error("serial receive slot wrong");
    converter_slot_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[22] && i_irq[21:0] == '0
        |=> o_level == 5'd22 && o_vector == 24'h008060 && !o_wake)
        else $error("converter slot wrong");
    byte_timer_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[23] && i_irq[22:0] == '0
        |=> o_level == 5'd23 && o_vector == 24'h008064)
        else $error("eight bit timer slot wrong");
    memory_slot_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[24] && i_irq[23:0] == '0
        |=> o_level == 5'd24 && o_vector == 24'h008068)
        else $error("data memory slot wrong");

    // ----------------------------------------------------------------
    // Wake and grant shape
    // ----------------------------------------------------------------
    // Wake follows the core state one cycle late, so a core that has just woken still sees wake for one cycle.
    wakeup_wake_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_halted && i_irq[1]
        |=> o_wake)
        else $error("auto wakeup did not wake");
    port_e_wake_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_halted && i_irq[7]
        |=> o_wake)
        else $error("port e line did not wake");
    spi_wake_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_halted && i_irq[10]
        |=> o_wake)
        else $error("spi did not wake");
    awake_quiet_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_halted
        |=> !o_wake)
        else $error("wake while core awake");
    idle_grant_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && (i_irq & 25'h1f9fcff) == '0
        |=> !o_valid)
        else $error("grant without request");
    numbered_valid_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_numbered
        |-> o_valid)
        else $error("numbered grant not valid");
    pick_order_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_trap && i_irq[12] && i_irq[20] && (i_irq[11:0] & 12'hcff) == '0
        |=> o_level == 5'd12)
        else $error("lower level not served first");

endmodule : ivpm_top
`default_nettype wire

// ===== tb/ivpm_core_model.sv
// Behavioural core that enters Halt on request and leaves it on a wake.
`timescale 1ns/1ps
`default_nettype none
module ivpm_core_model (
    // Clock
    input wire logic i_clk,
    // Sleep request and wake from the map
    input wire logic i_sleep,
    input wire logic i_wake,
    // Core state
    output logic o_halted
);
    // A held sleep request keeps the core halted, so a wake only shows once the request is dropped.
    always_ff @(posedge i_clk) begin
        o_halted <= i_sleep | (o_halted & ~i_wake);
    end
endmodule : ivpm_core_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench of the interrupt vector and priority map.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [24:0] i_irq = 25'h0;
    logic i_trap = 1'b0;
    logic sleep = 1'b0;
    logic halted;
    logic o_valid, o_numbered, o_wake;
    logic [4:0] o_level;
    logic [23:0] o_vector;
    int miscompares = 0;
    int check_count = 0;
    always #25 i_clk = ~i_clk;
    ivpm_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_irq(i_irq), .i_trap(i_trap), .i_halted(halted),
        .o_valid(o_valid), .o_numbered(o_numbered), .o_level(o_level), .o_vector(o_vector), .o_wake(o_wake));
    ivpm_core_model core (.i_clk(i_clk), .i_sleep(sleep), .i_wake(o_wake), .o_halted(halted));
    task automatic chk(input logic ok);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: grant differs", $time);
        end
    endtask : chk
    // Inputs change just after an edge; the grant is looked at one edge later.
    task automatic step(input logic [24:0] irq, input logic trap);
        @(posedge i_clk);
        #1;
        i_irq = irq;
        i_trap = trap;
        @(posedge i_clk);
        #1;
    endtask : step
    task automatic reset_check;
        i_srst = 1'b1;
        repeat (16) @(posedge i_clk);
        #1;
        chk(o_valid === 1'b1 && o_vector === 24'h008000 && o_numbered === 1'b0 && o_wake === 1'b1);
        i_srst = 1'b0;
    endtask : reset_check
    task automatic sweep_levels;
        logic used, cap;
        for (int n = 0; n < 25; n++) begin
            step(25'h1 << n, 1'b0);
            used = !(n inside {8, 9, 17, 18});
            cap = n inside {1, 3, 4, 5, 6, 7, 10, 19};
            chk(o_valid === used);
            chk(o_wake === (used & cap));
            if (used) begin
                chk(o_numbered === 1'b1 && o_level === 5'(n));
                chk(o_vector === 24'h008008 + 24'(4 * n));
            end
        end
    endtask : sweep_levels
    task automatic priority_and_trap;
        step(25'h1ffffff, 1'b0);
        chk(o_level === 5'h00 && o_vector === 24'h008008);
        step(25'h101300, 1'b0);
        chk(o_level === 5'h0c && o_vector === 24'h008038);
        step(25'h0, 1'b1);
        chk(o_valid === 1'b1 && o_numbered === 1'b0 && o_vector === 24'h008004 && o_wake === 1'b0);
        step(25'h1ffffff, 1'b1);
        chk(o_numbered === 1'b0 && o_vector === 24'h008004);
    endtask : priority_and_trap
    task automatic wake_exit;
        step(25'h0, 1'b0);
        chk(halted === 1'b1 && o_wake === 1'b0);
        sleep = 1'b0;
        step(25'h2, 1'b0);
        chk(o_wake === 1'b1 && halted === 1'b1);
        repeat (2) @(posedge i_clk);
        #1;
        chk(halted === 1'b0 && o_wake === 1'b0);
    endtask : wake_exit
    task automatic test_done;
        if (miscompares == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        reset_check();
        sleep = 1'b1;
        sweep_levels();
        priority_and_trap();
        wake_exit();
        reset_check();
        test_done();
    end
endmodule : testbench
`default_nettype wire
